// File: rtl/wwd_pkg.sv
// Shared constants, types and helpers of the window watchdog timer
package wwd_pkg;

  // Counter and prescaler geometry
  localparam int CNT_W = 16;
  localparam int PRE_W = 14;
  localparam logic [PRE_W-1:0] DIV_COARSE_LIMIT = 14'h3FFF;  // Divide by 16384
  localparam logic [PRE_W-1:0] DIV_FINE_LIMIT = 14'h00FF;    // Divide by 256
  localparam int DIV_FINE = 256;
  localparam logic [CNT_W-1:0] CNT_TOP = 16'hFFFF;

  // Default interval on the wake-up oscillator
  localparam int DFLT_TIME_MS = 130;
  localparam int WAKEUP_OSC_FREQ_HZ = 500000;
  localparam int DFLT_COUNTS = (DFLT_TIME_MS * (WAKEUP_OSC_FREQ_HZ / 1000) + DIV_FINE - 1) / DIV_FINE;
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'(32'h0001_0000 - 32'(DFLT_COUNTS));
  localparam logic [CNT_W-1:0] WINDOW_RST = 16'h0000;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;

  // Control fields
  localparam int CTRL_SRC_SYS_BIT = 0;   // 1: system clock, 0: wake-up oscillator
  localparam int CTRL_DIV_FINE_BIT = 1;  // 1: divide by 256, 0: by 16384
  localparam int CTRL_ENABLED_BIT = 2;   // Read only
  localparam logic [1:0] CTRL_RST = 2'h2;

  // Status and mask fields
  localparam int EVT_W = 3;
  localparam int EVT_OVERFLOW_BIT = 0;
  localparam int EVT_WINDOW_BIT = 1;
  localparam int EVT_SERVICE_BIT = 2;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

  // Supervision states, Gray along run -> off and run -> tripped
  typedef enum logic [1:0] {
    WWD_RUN = 2'b00,
    WWD_TRIP = 2'b01,
    WWD_OFF = 2'b10
  } wwd_state_t;

  // Count still below the programmed window boundary
  function automatic logic in_window(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] bound);
    in_window = cnt < bound;
  endfunction : in_window

endpackage : wwd_pkg

// File: rtl/wwd_prescaler.sv
// Selectable divide-by-16384 or divide-by-256 prescaler for the watchdog counter
`timescale 1ns/1ps
`default_nettype none
module wwd_prescaler (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Source and control
  input wire logic src_tick_i,
  input wire logic div_fine_i,
  input wire logic clear_i,
  // Divided tick
  output logic tick_o
);

  logic [wwd_pkg::PRE_W-1:0] pre_q;
  logic [wwd_pkg::PRE_W-1:0] limit;

  // Limit follows the ratio select live; a mid-period change to fine ends that period early, a change to coarse stretches it
  assign limit = div_fine_i ? wwd_pkg::DIV_FINE_LIMIT : wwd_pkg::DIV_COARSE_LIMIT;
  assign tick_o = src_tick_i && (pre_q >= limit) && !clear_i;

  // Divider count, restarted by every service so the interval starts clean
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_q <= 14'h0000;
    end else if (ce_i) begin
      if (clear_i) begin
        pre_q <= 14'h0000;
      end else if (src_tick_i) begin
        pre_q <= (pre_q >= limit) ? 14'h0000 : pre_q + 14'h0001;
      end
    end
  end

endmodule : wwd_prescaler
`default_nettype wire

// File: rtl/wwd_timer.sv
// Window watchdog timer top: counter, supervision control, registers and interrupt
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - After every reset the watchdog is enabled and counts with no software action.
// - The off and on instructions stop or restart supervision at any time until a reset request is raised.
// - Software must service before overflow, and an overflow raises a reset request.
// - A service while supervising with the count below the window boundary raises a reset request.
// - The counter is sixteen bits wide and counts upward to overflow.
// - The count clock is system clock or wake-up oscillator, divided by 16384 or 256.
// - Each valid service loads the counter from the reload value register.
// - Reset defaults give about 0.13 s on a 500 kHz wake-up oscillator.
module wwd_timer (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Count sources
  input wire logic wakeup_osc_clk_i,
  // CPU instructions, one-cycle pulses
  input wire logic service_instruction_i,
  input wire logic supervision_off_instruction_i,
  input wire logic supervision_on_instruction_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Outputs to the system
  output logic reset_request_o,
  output logic irq_o,
  output logic enabled_o
);

  wwd_pkg::wwd_state_t state_q;
  wwd_pkg::wwd_state_t state_d;
  logic [15:0] count_q;
  logic [15:0] reload_value_register_q;
  logic [15:0] window_q;
  logic [1:0] ctrl_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [31:0] rdata_q;
  logic wu_prev_q;
  logic src_tick;
  logic tick;
  logic running;
  logic overflow;
  logic illegal;
  logic legal;
  logic [2:0] events;
  logic [2:0] w1c;
  logic wr_ctrl;
  logic wr_reload;
  logic wr_window;
  logic wr_status;
  logic wr_mask;

  // Register write decode
  assign wr_ctrl = reg_we_i && (reg_addr_i == wwd_pkg::OFS_CTRL);
  assign wr_reload = reg_we_i && (reg_addr_i == wwd_pkg::OFS_RELOAD);
  assign wr_window = reg_we_i && (reg_addr_i == wwd_pkg::OFS_WINDOW);
  assign wr_status = reg_we_i && (reg_addr_i == wwd_pkg::OFS_STATUS);
  assign wr_mask = reg_we_i && (reg_addr_i == wwd_pkg::OFS_MASK);

  // Wake-up oscillator edge; the pin is taken as synchronous, so one flop suffices
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wu_prev_q <= 1'b0;
    end else if (ce_i) begin
      wu_prev_q <= wakeup_osc_clk_i;
    end
  end

  // Source select: every system cycle, or each rising oscillator edge
  assign src_tick = ctrl_q[wwd_pkg::CTRL_SRC_SYS_BIT] ? 1'b1 : (wakeup_osc_clk_i && !wu_prev_q);

  wwd_prescaler u_prescaler (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .src_tick_i(src_tick && running),
    .div_fine_i(ctrl_q[wwd_pkg::CTRL_DIV_FINE_BIT]),
    .clear_i(service_instruction_i),
    .tick_o(tick)
  );

  wwd_window_check u_window (
    .count_i(count_q),
    .boundary_i(window_q),
    .service_i(service_instruction_i),
    .armed_i(running),
    .illegal_o(illegal),
    .legal_o(legal)
  );

  assign running = (state_q == wwd_pkg::WWD_RUN);
  // Overflow only while supervising; a same-cycle service wins
  assign overflow = running && tick && (count_q == wwd_pkg::CNT_TOP) && !service_instruction_i;

  // Supervision state; a raised request is kept until the system resets us
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      wwd_pkg::WWD_RUN: begin
        if (overflow || illegal) begin
          state_d = wwd_pkg::WWD_TRIP;
        end else if (supervision_off_instruction_i) begin
          state_d = wwd_pkg::WWD_OFF;
        end
      end
      wwd_pkg::WWD_OFF: begin
        if (supervision_on_instruction_i) begin
          state_d = wwd_pkg::WWD_RUN;
        end
      end
      wwd_pkg::WWD_TRIP: begin
        state_d = wwd_pkg::WWD_TRIP;
      end
      default: begin
        state_d = wwd_pkg::WWD_TRIP;  // Illegal code fails safe
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= wwd_pkg::WWD_RUN;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // Up-counter; holds while off or tripped, reload on legal service or on overflow
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= wwd_pkg::RELOAD_RST;
    end else if (ce_i) begin
      if (legal) begin
        count_q <= reload_value_register_q;
      end else if (overflow) begin
        count_q <= reload_value_register_q;
      end else if (running && tick) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // Reset request level, cleared only by the system reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reset_request_o <= 1'b0;
    end else if (ce_i) begin
      if (overflow || illegal) begin
        reset_request_o <= 1'b1;
      end
    end
  end

  // Control and timing configuration registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= wwd_pkg::CTRL_RST;
      reload_value_register_q <= wwd_pkg::RELOAD_RST;
      window_q <= wwd_pkg::WINDOW_RST;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i[1:0];
      end
      if (wr_reload) begin
        reload_value_register_q <= reg_wdata_i[15:0];
      end
      if (wr_window) begin
        window_q <= reg_wdata_i[15:0];
      end
    end
  end

  // Sticky events; a new event beats a same-cycle write-one clear
  assign events = {legal, illegal, overflow};
  assign w1c = wr_status ? reg_wdata_i[2:0] : 3'h0;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_q <= 3'h0;
      mask_q <= wwd_pkg::MASK_RST;
    end else if (ce_i) begin
      status_q <= (status_q & ~w1c) | events;
      if (wr_mask) begin
        mask_q <= reg_wdata_i[2:0];
      end
    end
  end

  assign irq_o = |(status_q & mask_q);
  assign enabled_o = running;

  // Read data, valid only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_q <= 32'h0000_0000;
      if (reg_re_i) begin
        unique case (reg_addr_i)
          wwd_pkg::OFS_CTRL: begin
            rdata_q <= {29'h0000_0000, running, ctrl_q};
          end
          wwd_pkg::OFS_RELOAD: begin
            rdata_q <= {16'h0000, reload_value_register_q};
          end
          wwd_pkg::OFS_WINDOW: begin
            rdata_q <= {16'h0000, window_q};
          end
          wwd_pkg::OFS_COUNT: begin
            rdata_q <= {16'h0000, count_q};
          end
          wwd_pkg::OFS_STATUS: begin
            rdata_q <= {29'h0000_0000, status_q};
          end
          wwd_pkg::OFS_MASK: begin
            rdata_q <= {29'h0000_0000, mask_q};
          end
          default: begin
            rdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_q;

  // Checks; all sampled on the system clock and disabled while reset is asserted
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // Enabled right out of reset
  logic first_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  chk_enabled_after_reset: assert property (first_q |-> running && (count_q == wwd_pkg::RELOAD_RST))
    else $error("watchdog not running from reset reload");

  chk_off_instruction_stops: assert property (
    ce_i && running && supervision_off_instruction_i && !overflow && !illegal |=> state_q == wwd_pkg::WWD_OFF)
    else $error("off instruction did not stop supervision");

  chk_on_instruction_starts: assert property (
    ce_i && (state_q == wwd_pkg::WWD_OFF) && supervision_on_instruction_i |=> running)
    else $error("on instruction did not restart supervision");

  chk_overflow_requests_reset: assert property (
    ce_i && running && tick && (count_q == wwd_pkg::CNT_TOP) && !service_instruction_i
    |=> reset_request_o && (state_q == wwd_pkg::WWD_TRIP) && status_q[wwd_pkg::EVT_OVERFLOW_BIT])
    else $error("overflow without reset request");

  chk_early_service_trips: assert property (
    ce_i && running && service_instruction_i && wwd_pkg::in_window(count_q, window_q)
    |=> reset_request_o && $stable(count_q))
    else $error("early refresh not treated as violation");

  chk_count_steps_up: assert property (
    ce_i && running && tick && !service_instruction_i && (count_q != wwd_pkg::CNT_TOP)
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not step up by one");

  // Prescaler period in source ticks; pauses with the divider while not running
  // A control write leaves the running period unjudged, since its ratio may change midway
  logic [14:0] gap_q;
  logic gap_valid_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_q <= 15'h0000;
      gap_valid_q <= 1'b1;
    end else if (ce_i) begin
      if (service_instruction_i || tick) begin
        gap_q <= 15'h0000;
        gap_valid_q <= 1'b1;
      end else begin
        if (src_tick && running) begin
          gap_q <= gap_q + 15'h0001;
        end
        if (wr_ctrl) begin
          gap_valid_q <= 1'b0;
        end
      end
    end
  end

  chk_prescale_ratio: assert property (
    ce_i && tick && gap_valid_q
    |-> gap_q == (ctrl_q[wwd_pkg::CTRL_DIV_FINE_BIT] ? 15'(wwd_pkg::DIV_FINE_LIMIT) : 15'(wwd_pkg::DIV_COARSE_LIMIT)))
    else $error("divided tick off the selected ratio");

  // A raised request must never drop before the system reset
  chk_request_sticky: assert property (reset_request_o |=> reset_request_o && !running)
    else $error("reset request or trip state dropped");

  chk_service_reloads: assert property (
    ce_i && service_instruction_i && !(running && wwd_pkg::in_window(count_q, window_q))
    |=> count_q == $past(reload_value_register_q))
    else $error("service did not load reload value");

  chk_default_interval: assert property (first_q |->
    (reload_value_register_q == 16'hFF02) && !ctrl_q[wwd_pkg::CTRL_SRC_SYS_BIT] && ctrl_q[wwd_pkg::CTRL_DIV_FINE_BIT])
    else $error("reset defaults do not give the default interval");

  chk_disabled_holds: assert property (
    ce_i && (state_q == wwd_pkg::WWD_OFF) && !service_instruction_i && !$past(reset_request_o)
    |=> $stable(count_q) && !reset_request_o)
    else $error("disabled watchdog counted or requested reset");

  cov_overflow: cover property (ce_i && overflow);
  cov_window_violation: cover property (ce_i && illegal);
  cov_legal_refresh: cover property (ce_i && running && legal ##1 running);
  cov_off_then_on: cover property (state_q == wwd_pkg::WWD_OFF ##[1:20] running);
  cov_coarse_tick: cover property (ce_i && tick && !ctrl_q[wwd_pkg::CTRL_DIV_FINE_BIT]);

endmodule : wwd_timer
`default_nettype wire

// File: rtl/wwd_window_check.sv
// Classifies a service request as legal refresh or window violation
`timescale 1ns/1ps
`default_nettype none
module wwd_window_check (
  // Counter view
  input wire logic [15:0] count_i,
  input wire logic [15:0] boundary_i,
  // Request
  input wire logic service_i,
  input wire logic armed_i,
  // Verdict
  output logic illegal_o,
  output logic legal_o
);

  logic early;

  // Early refresh only counts against an armed watchdog
  assign early = wwd_pkg::in_window(count_i, boundary_i);
  assign illegal_o = service_i && armed_i && early;
  assign legal_o = service_i && !(armed_i && early);

endmodule : wwd_window_check
`default_nettype wire

// File: test/wwd_cpu_model.sv
// CPU core model that executes the watchdog service, off and on instructions
`timescale 1ns/1ps
`default_nettype none
module wwd_cpu_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Instruction pulses
  output logic service_o,
  output logic off_o,
  output logic on_o
);
  // Quiet until told to execute something
  initial begin
    service_o = 1'b0;
    off_o = 1'b0;
    on_o = 1'b0;
  end

  // Op 0 service, 1 off, 2 on; gap idles to model a slow core
  task automatic issue(input int op, input int gap);
    while (rstn_i !== 1'b1) @(posedge clock_i);
    repeat (gap) @(posedge clock_i);
    @(posedge clock_i);
    service_o <= (op == 0);
    off_o <= (op == 1);
    on_o <= (op == 2);
    @(posedge clock_i);
    service_o <= 1'b0;
    off_o <= 1'b0;
    on_o <= 1'b0;
  endtask : issue
endmodule : wwd_cpu_model
`default_nettype wire

// File: test/wwd_timer_test.sv
// Self-checking testbench of the window watchdog timer
`timescale 1ns/1ps
`default_nettype none
module wwd_timer_test;
  // 254 counts of 256 wake-up ticks at 500 kHz give 0.13 s
  localparam logic [31:0] DFLT = 32'(65536 - 254);
  localparam logic [7:0] A_CNT = wwd_pkg::OFS_COUNT;
  localparam logic [7:0] A_ST = wwd_pkg::OFS_STATUS;
  localparam logic [7:0] A_REL = wwd_pkg::OFS_RELOAD;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic wu_clk = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  logic service, off, on, req, irq, enabled;
  int num_errors = 0;
  int samples_checked = 0;

  // 250 MHz system clock
  always #2 clock = ~clock;

  // Device and the core that drives its instructions
  wwd_timer i_wwd_timer (.clock_i(clock), .rstn_i(rstn), .ce_i(ce), .wakeup_osc_clk_i(wu_clk),
    .service_instruction_i(service), .supervision_off_instruction_i(off),
    .supervision_on_instruction_i(on), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .reset_request_o(req), .irq_o(irq), .enabled_o(enabled));
  wwd_cpu_model i_wwd_cpu_model (.clock_i(clock), .rstn_i(rstn), .service_o(service), .off_o(off),
    .on_o(on));

  // Compare helpers, one per result kind
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // Register port cycles; read data is valid only one cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clock);
    we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    #1;
    chk_word(what, exp, rdata);
  endtask : reg_rd

  // Timing helpers
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic op(input int code);
    i_wwd_cpu_model.issue(code, 0);
    #1;
  endtask : op
  task automatic do_reset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
  endtask : do_reset
  task automatic wu_edges(input int n);
    repeat (n) begin
      @(posedge clock);
      wu_clk <= 1'b1;
      repeat (2) @(posedge clock);
      wu_clk <= 1'b0;
      @(posedge clock);
    end
    settle(4);
  endtask : wu_edges

  // Scenarios
  task automatic t_defaults();
    chk_bit("enabled", 1'b1, enabled);
    chk_bit("request", 1'b0, req);
    reg_rd(wwd_pkg::OFS_CTRL, 32'h0000_0006, "ctrl");
    reg_rd(A_REL, DFLT, "reload");
    reg_rd(A_CNT, DFLT, "count");
    reg_rd(wwd_pkg::OFS_WINDOW, 32'h0000_0000, "window");
    reg_rd(A_ST, 32'h0000_0000, "status");
    reg_rd(8'h20, 32'h0000_0000, "unmapped");
  endtask : t_defaults
  task automatic t_wakeup();
    wu_edges(255);
    reg_rd(A_CNT, DFLT, "count 255");
    wu_edges(1);
    reg_rd(A_CNT, DFLT + 1, "count 256");
  endtask : t_wakeup
  task automatic t_off_on();
    reg_wr(wwd_pkg::OFS_CTRL, 32'h0000_0003);
    op(0);
    op(1);
    chk_bit("enabled off", 1'b0, enabled);
    settle(600);
    reg_rd(A_CNT, DFLT, "held");
    chk_bit("request off", 1'b0, req);
    op(2);
    chk_bit("enabled on", 1'b1, enabled);
    settle(600);
    reg_rd(A_CNT, DFLT + 2, "resumed");
  endtask : t_off_on
  task automatic t_coarse();
    reg_wr(wwd_pkg::OFS_CTRL, 32'h0000_0001);
    reg_wr(wwd_pkg::OFS_MASK, 32'h0000_0004);
    settle(1);
    chk_bit("irq set", 1'b1, irq);
    reg_wr(A_ST, 32'h0000_0007);
    settle(1);
    chk_bit("irq clear", 1'b0, irq);
    op(0);
    chk_bit("irq again", 1'b1, irq);
    settle(16370);
    reg_rd(A_CNT, DFLT, "coarse early");
    settle(20);
    reg_rd(A_CNT, DFLT + 1, "coarse tick");
    // A service while the clock enable is low must not be taken
    @(posedge clock);
    ce <= 1'b0;
    op(0);
    @(posedge clock);
    ce <= 1'b1;
    reg_rd(A_CNT, DFLT + 1, "frozen by enable");
  endtask : t_coarse
  task automatic t_overflow();
    int n = 0;
    do_reset();
    reg_wr(wwd_pkg::OFS_CTRL, 32'h0000_0003);
    reg_wr(wwd_pkg::OFS_MASK, 32'h0000_0001);
    reg_wr(A_REL, 32'h0000_FFFE);
    op(0);
    reg_rd(A_CNT, 32'h0000_FFFE, "reloaded");
    chk_bit("irq masked", 1'b0, irq);
    settle(490);
    chk_bit("early request", 1'b0, req);
    while (req !== 1'b1 && n < 60) begin
      settle(1);
      n++;
    end
    chk_bit("overflow request", 1'b1, req);
    chk_bit("irq overflow", 1'b1, irq);
    reg_rd(A_ST, 32'h0000_0005, "status");
    op(2);
    chk_bit("sticky", 1'b1, req);
    reg_wr(A_ST, 32'h0000_0001);
    settle(1);
    chk_bit("irq w1c", 1'b0, irq);
  endtask : t_overflow
  task automatic t_window();
    do_reset();
    reg_wr(wwd_pkg::OFS_WINDOW, 32'h0000_8000);
    reg_wr(A_REL, 32'h0000_8000);
    op(0);
    op(0);
    chk_bit("at boundary", 1'b0, req);
    reg_wr(A_REL, 32'h0000_7FFF);
    op(0);
    reg_rd(A_CNT, 32'h0000_7FFF, "reload");
    op(0);
    chk_bit("inside window", 1'b1, req);
    reg_rd(A_ST, 32'h0000_0006, "status");
    reg_rd(A_CNT, 32'h0000_7FFF, "frozen");
  endtask : t_window

  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    do_reset();
    settle(1);
    t_defaults();
    t_wakeup();
    t_off_on();
    t_coarse();
    t_overflow();
    t_window();
    conclude();
  end

  // Whole run needs about 19000 cycles; cut a hang well beyond that
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    $display("[FAIL] watchdog expired");
    conclude();
  end
endmodule : wwd_timer_test
`default_nettype wire
